// ### config_prom_enable_revision_ctrl.sv
// enable, reset, chain and revision control of a configuration prom
`timescale 1ns/10ps
`default_nettype none

// Function
// [R1] oe/reset low: counter held reset, data and clock outputs released
// [R2] oe/reset pin driven low until power-on sequence ends
// [R3] oe/reset is always active low, no polarity option
// [R4] chip enable high: standby, counter reset, data and clock released
// [R5] reconfiguration command pulses the open-drain config pulse pin low
// [R6] config pulse rising edge samples revision, loads its start address
// [R7] chain enable low only if enabled and counter passed limit
// [R8] source pin low picks revision pins, high picks internal bits
// [R9] two revision pins override internal bits when pin selection active
// [R10] undriven selection and revision pins read as one
// [R11] clock edge advances counter only when enabled, not busy in parallel mode, pulse high
// [R12] clock output released when chip enable high or oe/reset low
// [R13] one start address held for each of four revisions
module config_prom_enable_revision_ctrl (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic linkClk,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // output enable / reset, open drain
    input wire logic oeResetIn,
    output logic oeResetOut,
    output logic oeResetOeN,
    // config pulse, open drain
    input wire logic configPulseNIn,
    output logic configPulseNOut,
    output logic configPulseOeN,
    // enables and handshake
    input wire logic chipEnableN,
    input wire logic busy,
    output logic chainEnableOutN,
    output logic standby,
    // revision selection
    input wire logic revisionSourcePinsN,
    input wire logic revisionPickBit0,
    input wire logic revisionPickBit1,
    // data path control and configuration clock
    output logic [config_prom_pkg::ADDR_W-1:0] fetchAddr,
    output logic dataOeN,
    output logic cfgClockOut,
    output logic cfgClockOeN
);

    localparam int AW = config_prom_pkg::ADDR_W;

    // ------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------
    // link clock may stop; only a toggle leaves this domain
    logic [1:0] linkRstSync_r;
    logic linkTog_r;

    always_ff @(posedge linkClk) begin
        linkRstSync_r <= {linkRstSync_r[0], nrst};
    end

    always_ff @(posedge linkClk) begin
        if (!linkRstSync_r[1]) begin
            linkTog_r <= 1'b0;
        end else begin
            linkTog_r <= ~linkTog_r;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [config_prom_pkg::SYNC_W-1:0] syncOut;
    logic oeS;
    logic ceNS;
    logic cfS;
    logic busyS;
    logic srcNS;
    logic [1:0] pinRevS;
    logic linkTogS;

    // [R10] pulled-up pins start as one
    pin_sync #(
        .WIDTH(config_prom_pkg::SYNC_W),
        .RST_VAL(config_prom_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .din({oeResetIn, chipEnableN, configPulseNIn, busy, revisionSourcePinsN,
              revisionPickBit1, revisionPickBit0, linkTog_r}),
        .dout(syncOut)
    );

    assign {oeS, ceNS, cfS, busyS, srcNS, pinRevS, linkTogS} = syncOut;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [config_prom_pkg::CTRL_W-1:0] ctrl_r;
    logic [AW-1:0] lastAddressLimit_r;
    logic [AW-1:0] startAddr_r [config_prom_pkg::REV_COUNT];
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rdVal;
    logic cmdStart;
    logic oscSel;
    logic clkOutEn;
    logic parMode;
    logic [1:0] ctrlRev;

    assign oscSel = ctrl_r[config_prom_pkg::CTRL_OSC_BIT];
    assign clkOutEn = ctrl_r[config_prom_pkg::CTRL_CFG_CLOCK_OUT_BIT];
    assign parMode = ctrl_r[config_prom_pkg::CTRL_PAR_BIT];
    assign ctrlRev = ctrl_r[config_prom_pkg::CTRL_REV_LSB +: 2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign cmdStart = wrPend_r && (wrAddr_r == config_prom_pkg::REG_CMD)
        && hwdata[config_prom_pkg::CMD_CONFIG_BIT];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else if (clkEn) begin
            wrPend_r <= hsel && htrans[1] && hready && hwrite;
            wrAddr_r <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata_r <= rdVal;
            end
        end
    end

    // [R13] start address per revision
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_r <= config_prom_pkg::CTRL_RST;
            lastAddressLimit_r <= config_prom_pkg::LIMIT_RST;
            for (int i = 0; i < config_prom_pkg::REV_COUNT; i++) begin
                startAddr_r[i] <= AW'(i << config_prom_pkg::REV_SHIFT);
            end
        end else if (clkEn && wrPend_r) begin
            if (wrAddr_r == config_prom_pkg::REG_CTRL) begin
                ctrl_r <= hwdata[config_prom_pkg::CTRL_W-1:0];
            end
            if (wrAddr_r == config_prom_pkg::REG_LIMIT) begin
                lastAddressLimit_r <= hwdata[AW-1:0];
            end
            if (wrAddr_r[7:4] == config_prom_pkg::REG_START_PAGE) begin
                startAddr_r[wrAddr_r[3:2]] <= hwdata[AW-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // power-on sequence and oe/reset pin
    // ------------------------------------------------------------
    logic [config_prom_pkg::CNT_W-1:0] porCnt_r;
    logic oeResetOeN_r;

    // [R2] hold oe/reset low during power-on
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            porCnt_r <= config_prom_pkg::CNT_W'(config_prom_pkg::POR_CYC);
            oeResetOeN_r <= 1'b0;
        end else if (clkEn && porCnt_r != '0) begin
            porCnt_r <= porCnt_r - 1'b1;
            oeResetOeN_r <= (porCnt_r == 8'h01);
        end
    end

    assign oeResetOut = 1'b0;
    assign oeResetOeN = oeResetOeN_r;

    // ------------------------------------------------------------
    // reconfiguration pulse driver
    // ------------------------------------------------------------
    logic [config_prom_pkg::CNT_W-1:0] cfCnt_r;
    logic cfOeN_r;

    // [R5] command drives config pulse low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfCnt_r <= '0;
            cfOeN_r <= 1'b1;
        end else if (clkEn) begin
            if (cmdStart) begin
                cfCnt_r <= config_prom_pkg::CNT_W'(config_prom_pkg::CFG_PULSE_CYC);
                cfOeN_r <= 1'b0;
            end else if (cfCnt_r != '0) begin
                cfCnt_r <= cfCnt_r - 1'b1;
                cfOeN_r <= (cfCnt_r == 8'h01);
            end
        end
    end

    assign configPulseNOut = 1'b0;
    assign configPulseOeN = cfOeN_r;

    // ------------------------------------------------------------
    // clock sources
    // ------------------------------------------------------------
    logic [config_prom_pkg::CNT_W-1:0] oscCnt_r;
    logic oscLevel_r;
    logic oscTick;
    logic linkTogPrev_r;
    logic linkTick;
    logic tick;

    assign oscTick = (oscCnt_r == '0) && !oscLevel_r;
    assign linkTick = linkTogS ^ linkTogPrev_r;
    assign tick = oscSel ? oscTick : linkTick;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            oscCnt_r <= config_prom_pkg::CNT_W'(config_prom_pkg::OSC_HALF_CYC - 1);
            oscLevel_r <= 1'b0;
            linkTogPrev_r <= 1'b0;
        end else if (clkEn) begin
            linkTogPrev_r <= linkTogS;
            if (oscCnt_r == '0) begin
                oscCnt_r <= config_prom_pkg::CNT_W'(config_prom_pkg::OSC_HALF_CYC - 1);
                oscLevel_r <= ~oscLevel_r;
            end else begin
                oscCnt_r <= oscCnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // address counter, revision load, chain enable
    // ------------------------------------------------------------
    logic cfPrev_r;
    logic cfRise;
    logic enabled;
    logic advance;
    logic [1:0] selRev;
    logic [AW-1:0] loadVal;
    logic [AW-1:0] pinStart;
    logic [AW-1:0] addr_r;
    logic passed_r;
    logic [1:0] curRev_r;

    // [R3] fixed active-low oe/reset
    assign enabled = oeS && !ceNS;
    assign cfRise = cfS && !cfPrev_r;
    // [R8] source pin chooses pins or bits
    assign selRev = srcNS ? ctrlRev : pinRevS;
    assign loadVal = startAddr_r[selRev];
    assign pinStart = startAddr_r[pinRevS];
    // [R11] advance gating
    assign advance = tick && enabled && !(parMode && busyS) && cfS;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfPrev_r <= 1'b1;
        end else if (clkEn) begin
            cfPrev_r <= cfS;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            addr_r <= '0;
            passed_r <= 1'b0;
            curRev_r <= 2'h0;
        end else if (clkEn) begin
            // [R1] [R4] counter held reset
            if (!enabled) begin
                addr_r <= '0;
                passed_r <= 1'b0;
            // [R6] [R9] revision reload
            end else if (cfRise) begin
                addr_r <= loadVal;
                passed_r <= 1'b0;
                curRev_r <= selRev;
            end else if (advance) begin
                addr_r <= addr_r + 1'b1;
                if (addr_r == lastAddressLimit_r) begin
                    passed_r <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    logic chainN_r;
    logic standby_r;
    logic dataOeN_r;
    logic cfg_clock_out_r;
    logic clkOeN_r;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chainN_r <= 1'b1;
            standby_r <= 1'b1;
            dataOeN_r <= 1'b1;
            cfg_clock_out_r <= 1'b0;
            clkOeN_r <= 1'b1;
        end else if (clkEn) begin
            // [R7] chain enable
            chainN_r <= !(enabled && passed_r);
            standby_r <= ceNS;
            dataOeN_r <= !enabled;
            // [R12] clock output release
            clkOeN_r <= !(enabled && clkOutEn);
            cfg_clock_out_r <= oscSel ? oscLevel_r : linkTick;
        end
    end

    assign chainEnableOutN = chainN_r;
    assign standby = standby_r;
    assign dataOeN = dataOeN_r;
    assign cfgClockOut = cfg_clock_out_r;
    assign cfgClockOeN = clkOeN_r;
    assign fetchAddr = addr_r;

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always_comb begin
        rdVal = 32'h0000_0000;
        case (haddr[7:0])
            config_prom_pkg::REG_CTRL: rdVal[config_prom_pkg::CTRL_W-1:0] = ctrl_r;
            config_prom_pkg::REG_LIMIT: rdVal[AW-1:0] = lastAddressLimit_r;
            config_prom_pkg::REG_ADDR: rdVal[AW-1:0] = addr_r;
            config_prom_pkg::REG_STATUS: rdVal[6:0] = {oeS, curRev_r, !cfOeN_r,
                standby_r, passed_r, oeResetOeN_r};
            default: begin
                if (haddr[7:4] == config_prom_pkg::REG_START_PAGE) begin
                    rdVal[AW-1:0] = startAddr_r[haddr[3:2]];
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    oe_reset_a: assert property ((clkEn && !oeS) |=> // [R1]
        (addr_r == '0) && dataOeN_r && clkOeN_r)
        else $error("oe low did not reset counter and release outputs");
    por_drive_a: assert property ((porCnt_r != '0) |-> !oeResetOeN_r) // [R2]
        else $error("oe/reset released before power-on done");
    por_release_a: assert property ((clkEn && porCnt_r == 8'h01) |=> oeResetOeN_r) // [R2]
        else $error("oe/reset not released after power-on");
    active_low_a: assert property ((clkEn && oeS && !ceNS) |=> !dataOeN_r) // [R3]
        else $error("data not enabled with oe high and chip enabled");
    standby_mode_a: assert property ((clkEn && ceNS) |=> // [R4]
        standby_r && (addr_r == '0) && dataOeN_r)
        else $error("chip disable did not enter standby");
    cfg_pulse_a: assert property ((clkEn && cmdStart) |=> !cfOeN_r [*8]) // [R5]
        else $error("config pulse not driven low after command");
    rev_load_a: assert property ((clkEn && enabled && cfRise) |=> // [R6]
        (addr_r == $past(loadVal)))
        else $error("revision start address not loaded");
    chain_high_a: assert property ((clkEn && !enabled) |=> chainN_r) // [R7]
        else $error("chain enable low while disabled");
    chain_low_a: assert property ((clkEn && enabled && passed_r) |=> !chainN_r) // [R7]
        else $error("chain enable high after passing limit");
    pin_select_a: assert property ((clkEn && enabled && cfRise && !srcNS) |=> // [R8] [R9]
        (addr_r == $past(pinStart)))
        else $error("revision pins did not pick start address");
    advance_step_a: assert property ((clkEn && advance && !cfRise && enabled) |=> // [R11]
        (addr_r == $past(addr_r) + 22'h1))
        else $error("counter did not advance on clock edge");
    advance_hold_a: assert property ((clkEn && enabled && !cfS && !cfRise) |=> // [R11]
        $stable(addr_r))
        else $error("counter moved while config pulse low");
    clk_off_a: assert property ((clkEn && !enabled) |=> clkOeN_r) // [R12]
        else $error("clock output driven while disabled");

    advance_c: cover property (clkEn && advance);
    chain_c: cover property (!chainN_r);
    reload_c: cover property (clkEn && enabled && cfRise);
    pulse_c: cover property (clkEn && cmdStart);

endmodule : config_prom_enable_revision_ctrl

`default_nettype wire

// ### config_prom_pkg.sv
// constants shared by the configuration prom control block
`default_nettype none

package config_prom_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int REV_COUNT = 4;
    localparam int REV_SHIFT = 20;
    localparam int SYNC_W = 8;

    // ------------------------------------------------------------
    // timing: ref_clk period and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    // internal oscillator period, a longest half period rounds down
    localparam int OSC_PERIOD_NS = 30;
    localparam int OSC_HALF_RAW = (OSC_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int OSC_HALF_CYC = (OSC_HALF_RAW < 1) ? 1 : OSC_HALF_RAW;
    // least width of the reconfiguration pulse, rounds up
    localparam int CFG_PULSE_NS = 500;
    localparam int CFG_PULSE_CYC = (CFG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // power-on reset sequence length, rounds up
    localparam int POR_NS = 1000;
    localparam int POR_CYC = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] REG_ADDR = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [3:0] REG_START_PAGE = 4'h2;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_OSC_BIT = 0;
    localparam int CTRL_CFG_CLOCK_OUT_BIT = 1;
    localparam int CTRL_REV_LSB = 2;
    localparam int CTRL_PAR_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h02;
    localparam logic [ADDR_W-1:0] LIMIT_RST = 22'h3f_ffff;
    localparam int CMD_CONFIG_BIT = 0;

    // synchroniser order {oe, ceN, cf, busy, srcN, rev1, rev0, linkTog}
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'h6e;

endpackage : config_prom_pkg

`default_nettype wire

// ### fpga_side_model.sv
// far-side model: configuration logic of the programmable device and its pull-ups
`timescale 1ns/10ps
`default_nettype none

module fpga_side_model (
    // device open-drain enables
    input wire logic oeResetOeN,
    input wire logic configPulseOeN,
    // bench controls
    input wire logic holdOeLow,
    input wire logic holdCfLow,
    input wire logic pinsDrive,
    input wire logic [2:0] pinsVal,
    // pin levels seen by the device
    output logic oeResetIn,
    output logic configPulseNIn,
    output logic revisionSourcePinsN,
    output logic revisionPickBit1,
    output logic revisionPickBit0,
    output logic linkClk
);
    assign oeResetIn = !(holdOeLow || !oeResetOeN);
    assign configPulseNIn = !(holdCfLow || !configPulseOeN);
    assign {revisionSourcePinsN, revisionPickBit1, revisionPickBit0} = pinsDrive ? pinsVal : 3'h7;

    initial linkClk = 1'b0;

    // clock stands still between frames; odd offset keeps it off the main clock phase
    task automatic pulses(input int n);
        #1.3;
        for (int i = 0; i < n; i++) begin
            #7.5 linkClk = 1'b1;
            #7.5 linkClk = 1'b0;
        end
    endtask : pulses
endmodule : fpga_side_model
`default_nettype wire

// ### pin_sync.sv
// two flip-flop synchroniser for a group of independent pin levels
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    meta_r <= RST_VAL[i];
                    stable_r <= RST_VAL[i];
                end else if (clkEn) begin
                    meta_r <= din[i];
                    stable_r <= meta_r;
                end
            end
            assign dout[i] = stable_r;
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ### tb.sv
// self-checking bench for the configuration prom control block
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic chipEnableN = 1'b1;
    logic busy = 1'b0;
    logic holdOeLow = 1'b0;
    logic holdCfLow = 1'b0;
    logic pinsDrive = 1'b0;
    logic [2:0] pinsVal = 3'h7;
    logic clkEn = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, oeResetIn, oeResetOut, oeResetOeN, configPulseNIn, configPulseNOut;
    logic configPulseOeN, chainEnableOutN, standby, revisionSourcePinsN, revisionPickBit0;
    logic revisionPickBit1, dataOeN, cfgClockOut, cfgClockOeN, linkClk;
    logic [config_prom_pkg::ADDR_W-1:0] fetchAddr;
    int err_total = 0;
    int samples_checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    config_prom_enable_revision_ctrl u_config_prom_enable_revision_ctrl (
        .ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .linkClk(linkClk),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .oeResetIn(oeResetIn), .oeResetOut(oeResetOut),
        .oeResetOeN(oeResetOeN), .configPulseNIn(configPulseNIn),
        .configPulseNOut(configPulseNOut), .configPulseOeN(configPulseOeN),
        .chipEnableN(chipEnableN), .busy(busy), .chainEnableOutN(chainEnableOutN),
        .standby(standby), .revisionSourcePinsN(revisionSourcePinsN),
        .revisionPickBit0(revisionPickBit0), .revisionPickBit1(revisionPickBit1),
        .fetchAddr(fetchAddr), .dataOeN(dataOeN), .cfgClockOut(cfgClockOut),
        .cfgClockOeN(cfgClockOeN));

    fpga_side_model u_fpga_side_model (
        .oeResetOeN(oeResetOeN), .configPulseOeN(configPulseOeN), .holdOeLow(holdOeLow),
        .holdCfLow(holdCfLow), .pinsDrive(pinsDrive), .pinsVal(pinsVal),
        .oeResetIn(oeResetIn), .configPulseNIn(configPulseNIn),
        .revisionSourcePinsN(revisionSourcePinsN), .revisionPickBit1(revisionPickBit1),
        .revisionPickBit0(revisionPickBit0), .linkClk(linkClk));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // settled sample point, clear of the edge's own updates
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            err_total++;
            finish_test();
        end
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rreg

    task automatic cf_reload(input logic [31:0] exp);
        @(posedge ref_clk);
        holdCfLow <= 1'b1;
        cyc(4);
        @(posedge ref_clk);
        holdCfLow <= 1'b0;
        cyc(6);
        chk(fetchAddr, exp);
    endtask : cf_reload

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_por();
        cyc(10);
        chk({oeResetOeN, dataOeN, cfgClockOeN, fetchAddr}, 32'hc0_0000);
        chk({hreadyout, hresp, oeResetOut, configPulseNOut}, 32'h8);
        cyc(config_prom_pkg::POR_CYC - 20);
        chk(oeResetOeN, 32'h0);
        cyc(12);
        chk({oeResetOeN, dataOeN, cfgClockOeN, standby}, 32'h8);
        rreg(config_prom_pkg::REG_CTRL, 32'h2);
        rreg(config_prom_pkg::REG_LIMIT, 32'h3f_ffff);
        for (int i = 0; i < 4; i++) rreg(8'h20 + 8'(4 * i), 32'(i) << 20);
        ahb(1'b1, 8'h3c, 32'hffff_ffff);
        rreg(8'h3c, 32'h0);
    endtask : s_por

    task automatic s_enable();
        ahb(1'b1, config_prom_pkg::REG_LIMIT, 32'h3);
        u_fpga_side_model.pulses(3);
        cyc(6);
        chk({fetchAddr, chainEnableOutN}, 32'h7);
        u_fpga_side_model.pulses(1);
        cyc(6);
        chk({fetchAddr, chainEnableOutN}, 32'h8);
        rreg(config_prom_pkg::REG_ADDR, 32'h4);
        ahb(1'b1, config_prom_pkg::REG_CTRL, 32'h12);
        @(posedge ref_clk);
        busy <= 1'b1;
        cyc(4);
        u_fpga_side_model.pulses(2);
        cyc(6);
        chk(fetchAddr, 32'h4);
        @(posedge ref_clk);
        busy <= 1'b0;
        ahb(1'b1, config_prom_pkg::REG_CTRL, 32'h2);
        @(posedge ref_clk);
        chipEnableN <= 1'b1;
        cyc(6);
        chk({standby, dataOeN, cfgClockOeN, chainEnableOutN, fetchAddr}, 32'h3c0_0000);
    endtask : s_enable

    task automatic s_oe();
        @(posedge ref_clk);
        chipEnableN <= 1'b0;
        cyc(6);
        u_fpga_side_model.pulses(2);
        cyc(6);
        chk({dataOeN, cfgClockOeN, fetchAddr}, 32'h2);
        @(posedge ref_clk);
        holdOeLow <= 1'b1;
        cyc(6);
        u_fpga_side_model.pulses(2);
        cyc(6);
        chk({dataOeN, cfgClockOeN, fetchAddr}, 32'hc00_000);
        @(posedge ref_clk);
        holdOeLow <= 1'b0;
        cyc(6);
        chk({dataOeN, cfgClockOeN}, 32'h0);
    endtask : s_oe

    task automatic s_reload();
        @(posedge ref_clk);
        pinsDrive <= 1'b1;
        pinsVal <= 3'h2;
        ahb(1'b1, config_prom_pkg::REG_CMD, 32'h1);
        cyc(40);
        chk(configPulseOeN, 32'h0);
        u_fpga_side_model.pulses(2);
        cyc(2);
        chk(fetchAddr, 32'h0);
        cyc(60);
        chk({configPulseOeN, fetchAddr}, 32'h600_000);
        @(posedge ref_clk);
        pinsDrive <= 1'b0;
        ahb(1'b1, config_prom_pkg::REG_CTRL, 32'h6);
        cf_reload(32'h10_0000);
        @(posedge ref_clk);
        pinsDrive <= 1'b1;
        pinsVal <= 3'h3;
        cf_reload(32'h30_0000);
        rreg(config_prom_pkg::REG_STATUS, 32'h71);
    endtask : s_reload

    // internal oscillator drives counter and clock out; clock enable low freezes the counter
    task automatic s_osc();
        logic [config_prom_pkg::ADDR_W-1:0] a0;
        logic prev;
        int rises;
        ahb(1'b1, config_prom_pkg::REG_CTRL, 32'h3);
        cyc(2);
        a0 = fetchAddr;
        prev = cfgClockOut;
        rises = 0;
        for (int i = 0; i < 60; i++) begin
            cyc(1);
            if (cfgClockOut === 1'b1 && prev === 1'b0) rises++;
            prev = cfgClockOut;
        end
        chk(fetchAddr - a0, 32'(60 / (2 * config_prom_pkg::OSC_HALF_CYC)));
        chk(rises, 32'(60 / (2 * config_prom_pkg::OSC_HALF_CYC)));
        @(posedge ref_clk);
        clkEn <= 1'b0;
        cyc(1);
        a0 = fetchAddr;
        cyc(12);
        chk(fetchAddr, a0);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        cyc(2);
    endtask : s_osc

    initial begin
        fork
            u_fpga_side_model.pulses(4);
            begin
                repeat (6) @(posedge ref_clk);
                nrst <= 1'b1;
                chipEnableN <= 1'b0;
            end
        join
        s_por();
        s_enable();
        s_oe();
        s_reload();
        s_osc();
        finish_test();
    end
endmodule : tb
`default_nettype wire
